/* design/ddl_pkg.sv */
package ddl_pkg;
  localparam int WORD_BITS    = 16;
  localparam int DATA_BITS    = 12;
  localparam int POS_TSEL_HI  = 15;
  localparam int POS_SPEED    = 14;
  localparam int POS_POWER    = 13;
  localparam int POS_TSEL_LO  = 12;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [12:0] CODE_SPAN  = 13'h1000;
  localparam int MCLK_HZ      = 40_000_000;
  localparam int SCLK_MAX_HZ  = 20_000_000;
  // Clock divider half period in mclk cycles (rounded up keeps rate at or below max)
  localparam int SCLK_HALF_CYC = (MCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  // Settling times in ns and their mclk counts (all counts round down)
  localparam int SETTLE_FS_FAST_NS = 3000;
  localparam int SETTLE_FS_SLOW_NS = 7000;
  localparam int SETTLE_CC_FAST_NS = 1500;
  localparam int SETTLE_CC_SLOW_NS = 2000;
  localparam int MCLK_NS = 25;
  localparam int SETTLE_FS_FAST_CYC = SETTLE_FS_FAST_NS / MCLK_NS;
  localparam int SETTLE_FS_SLOW_CYC = SETTLE_FS_SLOW_NS / MCLK_NS;
  localparam int SETTLE_CC_FAST_CYC = SETTLE_CC_FAST_NS / MCLK_NS;
  localparam int SETTLE_CC_SLOW_CYC = SETTLE_CC_SLOW_NS / MCLK_NS;
  localparam int GAP_CYC = 4; // idle mclk cycles with select high between words; ddl_host does not use it and keeps select high one mclk cycle

  typedef enum logic [1:0] {
    TGT_DACB_BUF = 2'b00,
    TGT_BUF      = 2'b01,
    TGT_DACA_XFR = 2'b10,
    TGT_CTRL     = 2'b11
  } ddl_target_t;

  typedef enum logic [1:0] {
    VSRC_EXT0 = 2'b00,
    VSRC_1V024 = 2'b01,
    VSRC_2V048 = 2'b10,
    VSRC_EXT1 = 2'b11
  } ddl_vsource_t;

  // Settle wait in mclk cycles for a mode and a step size
  function automatic logic [15:0] settle_cycles(input logic fast, input logic full);
    logic [15:0] r;
    r = 16'h0000;
    if (full) r = fast ? 16'(SETTLE_FS_FAST_CYC) : 16'(SETTLE_FS_SLOW_CYC);
    else      r = fast ? 16'(SETTLE_CC_FAST_CYC) : 16'(SETTLE_CC_SLOW_CYC);
    return r;
  endfunction
endpackage

/* design/ddl_link_if.sv */
`timescale 1ns/1ps
// Three-wire write-only link; host drives all three lines
interface ddl_link_if;
  logic sel_n;
  logic sclk;
  logic sdata;
  modport host (output sel_n, output sclk, output sdata);
  modport dev  (input sel_n, input sclk, input sdata);
endinterface

/* design/ddl_device.sv */
`timescale 1ns/1ps
// Converter word loader: shift logic on the link clock, latches handed to mclk
module ddl_device
  import ddl_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  ddl_link_if.dev           link,
  output logic [11:0]       dac_a_code,
  output logic [11:0]       dac_b_code,
  output logic [11:0]       buf_code,
  output ddl_pkg::ddl_vsource_t vsource_sel,
  output logic              speed_select,
  output logic              power_down_bit,
  output logic              vsource_external,
  output logic [12:0]       out_scale_a,
  output logic [12:0]       out_scale_b,
  output logic              settling,
  output logic              update_pulse
);
  import ddl_pkg::*;

  // Link domain: shift register and bit count, cleared while select is high
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic [15:0] word_reg;
  logic        wtog_reg;
  logic        sel_fall_seen;
  wire  logic [15:0] full_word = {shift_reg[14:0], link.sdata};

  assign sel_fall_seen = ~link.sel_n;
  always_ff @(negedge link.sclk or posedge link.sel_n or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end else if (link.sel_n) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;                         // start on select fall
    end else if (count_reg != 5'(WORD_BITS)) begin
      // Falls past sixteen are ignored so the held word stays intact
      shift_reg <= full_word;                     // MSB first
      count_reg <= count_reg + 5'h01;
    end
  end

  // Word hand-off on sixteenth rising sclk edge; toggle carries event to mclk
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= 16'h0000;
      wtog_reg <= 1'b0;
    end else if (sel_fall_seen && count_reg == 5'(WORD_BITS)) begin
      word_reg <= shift_reg;
      wtog_reg <= ~wtog_reg;
    end
  end

  // mclk domain: synchronise toggle
  logic [2:0] tsync_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tsync_reg <= 3'b000;
    else        tsync_reg <= {tsync_reg[1:0], wtog_reg};
  end
  wire logic word_evt = tsync_reg[2] ^ tsync_reg[1];

  // Two-entry buffer between hand-off and latches
  logic [15:0] fifo_mem [2];
  logic        wp_reg, rp_reg;
  logic [1:0]  cnt_reg;
  wire  logic  f_in_valid  = word_evt;
  wire  logic  f_in_ready  = (cnt_reg != 2'd2);
  wire  logic  f_out_valid = (cnt_reg != 2'd0);
  wire  logic  f_out_ready = 1'b1;               // latches always accept
  wire  logic  f_push = f_in_valid & f_in_ready;
  wire  logic  f_pop  = f_out_valid & f_out_ready;
  wire  logic [15:0] cur = fifo_mem[rp_reg];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'd0;
      fifo_mem[0] <= 16'h0000;
      fifo_mem[1] <= 16'h0000;
    end else begin
      if (f_push) fifo_mem[wp_reg] <= word_reg;   // word_reg is stable long after toggle
      if (f_push) wp_reg <= ~wp_reg;
      if (f_pop)  rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, f_push} - {1'b0, f_pop};
    end
  end

  // Decode of the popped word
  wire ddl_target_t tgt = ddl_target_t'({cur[POS_TSEL_HI], cur[POS_TSEL_LO]});
  wire logic [11:0] data = cur[DATA_BITS-1:0];
  wire logic ld_b   = f_pop && tgt == TGT_DACB_BUF;
  wire logic ld_buf = f_pop && (tgt == TGT_DACB_BUF || tgt == TGT_BUF);
  wire logic ld_a   = f_pop && tgt == TGT_DACA_XFR;
  wire logic ld_xfr = f_pop && tgt == TGT_DACA_XFR;
  wire logic ld_ctl = f_pop && tgt == TGT_CTRL;
  wire logic [11:0] b_next = ld_b ? data : (ld_xfr ? buf_code : dac_b_code);
  wire logic [11:0] a_next = ld_a ? data : dac_a_code;
  function automatic logic big_step(input logic [11:0] o, input logic [11:0] n);
    return ((o > n) ? (o - n) : (n - o)) > 12'h001;
  endfunction
  wire logic full_step = big_step(dac_a_code, a_next) | big_step(dac_b_code, b_next);

  // Latches, cleared at power-on
  logic [15:0] settle_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dac_a_code     <= CODE_RESET;
      dac_b_code     <= CODE_RESET;
      buf_code       <= CODE_RESET;
      vsource_sel    <= VSRC_EXT0;
      speed_select   <= 1'b0;
      power_down_bit <= 1'b0;
      update_pulse   <= 1'b0;
      settle_reg     <= 16'h0000;
    end else begin
      update_pulse <= f_pop;
      if (ld_buf) buf_code <= data;
      dac_a_code <= a_next;
      dac_b_code <= b_next;
      if (ld_ctl) vsource_sel <= ddl_vsource_t'(data[1:0]);
      if (f_pop) begin
        speed_select   <= cur[POS_SPEED];
        power_down_bit <= cur[POS_POWER];
      end
      // Settle model: fast/slow and full-scale/one-count bounds
      if (f_pop && (ld_a || ld_b || ld_xfr))
        settle_reg <= settle_cycles(cur[POS_SPEED], full_step);
      else if (settle_reg != 16'h0000)
        settle_reg <= settle_reg - 16'h0001;
    end
  end
  assign settling = (settle_reg != 16'h0000);

  // Reference decode and code scale; volts = 2*ref*scale/4096
  assign vsource_external = (vsource_sel == VSRC_EXT0) || (vsource_sel == VSRC_EXT1);
  assign out_scale_a = {1'b0, dac_a_code};        // over CODE_SPAN
  assign out_scale_b = {1'b0, dac_b_code};
endmodule // ddl_device

/* design/ddl_host.sv */
`timescale 1ns/1ps
// Host end: takes 16-bit words, sends them MSB first with a divided clock
module ddl_host
  import ddl_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        word_valid,
  input  wire logic [15:0] word_data,
  output logic             word_ready,
  output logic             busy,
  ddl_link_if.host         link
);
  import ddl_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SEL   = 2'b01,
    H_SHIFT = 2'b11,
    H_GAP   = 2'b10
  } ddl_hst_t;
  ddl_hst_t    st_reg;
  logic [15:0] sh_reg;
  logic [4:0]  bit_reg;
  logic [7:0]  div_reg;
  logic        sclk_reg, sel_n_reg;

  // Two-entry buffer on the request side
  logic [15:0] q_mem [2];
  logic        qw_reg, qr_reg;
  logic [1:0]  qc_reg;
  wire logic q_out_valid = (qc_reg != 2'd0);
  wire logic q_pop  = q_out_valid && st_reg == H_IDLE;
  wire logic q_push = word_valid && word_ready;
  assign word_ready = (qc_reg != 2'd2);
  assign busy = (st_reg != H_IDLE) || q_out_valid;
  wire logic tick = (div_reg == 8'(HALF_CYC - 1));  // half period bound

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      qw_reg <= 1'b0;
      qr_reg <= 1'b0;
      qc_reg <= 2'd0;
      q_mem[0] <= 16'h0000;
      q_mem[1] <= 16'h0000;
    end else begin
      if (q_push) q_mem[qw_reg] <= word_data;
      if (q_push) qw_reg <= ~qw_reg;
      if (q_pop)  qr_reg <= ~qr_reg;
      qc_reg <= qc_reg + {1'b0, q_push} - {1'b0, q_pop};
    end
  end

  // Frame sequencer: select falls, 16 falling edges, then select rises
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= H_IDLE;
      sh_reg <= 16'h0000;
      bit_reg <= 5'h00;
      div_reg <= 8'h00;
      sclk_reg <= 1'b1;
      sel_n_reg <= 1'b1;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      unique case (st_reg)
        H_IDLE: begin
          div_reg <= 8'h00;
          if (q_pop) begin
            sh_reg <= q_mem[qr_reg];
            sel_n_reg <= 1'b0;
            st_reg <= H_SEL;
          end
        end
        H_SEL: if (tick) st_reg <= H_SHIFT;
        H_SHIFT: if (tick) begin
          sclk_reg <= ~sclk_reg;
          if (!sclk_reg) begin
            sh_reg <= {sh_reg[14:0], 1'b0};
            bit_reg <= bit_reg + 5'h01;
            if (bit_reg == 5'(WORD_BITS - 1)) begin
              st_reg <= H_GAP;                    // whole word under one select
            end
          end
        end
        H_GAP: if (tick) begin
          sel_n_reg <= 1'b1;                      // one tick after sixteenth rise
          bit_reg <= 5'h00;
          st_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign link.sel_n = sel_n_reg;
  assign link.sclk  = sclk_reg;
  assign link.sdata = sh_reg[15];                 // MSB first
endmodule // ddl_host

/* testbench/ddl_link_props.sv */
`timescale 1ns/1ps
// Link wire checks, all sampled on mclk
module ddl_link_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdata
);
  logic       sclk_reg;
  logic [4:0] fall_cnt_reg;
  logic [4:0] fall_cnt_next;
  wire        sclk_fell;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Falls per frame; cleared while deselected so a frame counts afresh
  assign sclk_fell     = sclk_reg && !sclk;
  assign fall_cnt_next = sel_n ? 5'h00 : (sclk_fell ? fall_cnt_reg + 5'h01 : fall_cnt_reg);

  // Short on purpose: previous clock level and the fall count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg     <= 1'b1;
      fall_cnt_reg <= 5'h00;
    end else begin
      sclk_reg     <= sclk;
      fall_cnt_reg <= fall_cnt_next;
    end
  end

  // Clock high when the select drop is seen and one tick more, then falls
  sequence s_first_fall;
    sclk ##1 sclk ##1 !sclk;
  endsequence

  AST_IDLE_CLK_HIGH: assert property (sel_n |-> sclk)
    else $error("link clock low while deselected");
  AST_FIRST_FALL: assert property ($fell(sel_n) |-> s_first_fall)
    else $error("first clock fall misplaced");
  AST_LOW_WIDTH: assert property ($fell(sclk) |=> sclk)
    else $error("clock low phase wrong");
  AST_HIGH_WIDTH: assert property ($rose(sclk) |=> !sclk || sel_n)
    else $error("clock high phase wrong");
  AST_FALL_SELECTED: assert property ($fell(sclk) |-> !sel_n)
    else $error("clock fall outside frame");
  AST_SIXTEEN_FALLS: assert property ($rose(sel_n) |-> fall_cnt_reg == 5'h10)
    else $error("frame not sixteen bits");
  AST_COUNT_CAP: assert property (fall_cnt_reg <= 5'h10)
    else $error("frame longer than sixteen bits");
  AST_DATA_SETUP: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at clock fall");
endmodule // ddl_link_props

/* testbench/tb_top.sv */
`timescale 1ns/1ps
// Host end drives device end; device latches checked per word
module tb_top;
  import ddl_pkg::*;
  logic         mclk;
  logic         rst_n;
  logic         word_valid;
  logic [15:0]  word_data;
  logic         word_ready;
  logic         busy;
  logic [11:0]  dac_a_code;
  logic [11:0]  dac_b_code;
  logic [11:0]  buf_code;
  ddl_vsource_t vsource_sel;
  logic         speed_select;
  logic         power_down_bit;
  logic         vsource_external;
  logic [12:0]  out_scale_a;
  logic [12:0]  out_scale_b;
  logic         settling;
  logic         update_pulse;
  logic [39:0]  seen;
  int           err_count = 0;
  int           total_checks = 0;
  int           stl;
  int           n;
  // Word, dac a, dac b, buffer, speed and power
  logic [15:0]  tbl [6][5] = '{'{16'h4abc, 16'h000, 16'habc, 16'habc, 16'h2},
    '{16'h4abd, 16'h000, 16'habd, 16'habd, 16'h2}, '{16'h1123, 16'h000, 16'habd, 16'h123, 16'h0},
    '{16'h8fff, 16'hfff, 16'h123, 16'h123, 16'h0}, '{16'h0124, 16'hfff, 16'h124, 16'h124, 16'h0},
    '{16'h2000, 16'hfff, 16'h000, 16'h000, 16'h1}};
  int           sexp [6] = '{SETTLE_FS_FAST_CYC, SETTLE_CC_FAST_CYC, 0, SETTLE_FS_SLOW_CYC,
    SETTLE_CC_SLOW_CYC, 0};

  ddl_link_if link_bus ();
  ddl_host u_ddl_host (.mclk(mclk), .rst_n(rst_n), .word_valid(word_valid),
    .word_data(word_data), .word_ready(word_ready), .busy(busy), .link(link_bus));
  ddl_device u_ddl_device (.mclk(mclk), .rst_n(rst_n), .link(link_bus), .dac_a_code(dac_a_code),
    .dac_b_code(dac_b_code), .buf_code(buf_code), .vsource_sel(vsource_sel),
    .speed_select(speed_select), .power_down_bit(power_down_bit),
    .vsource_external(vsource_external), .out_scale_a(out_scale_a), .out_scale_b(out_scale_b),
    .settling(settling), .update_pulse(update_pulse));
  ddl_link_props u_ddl_link_props (.mclk(mclk), .rst_n(rst_n), .sel_n(link_bus.sel_n),
    .sclk(link_bus.sclk), .sdata(link_bus.sdata));

  // Latch state gathered for one-line compares
  assign seen = {dac_a_code, dac_b_code, buf_code, vsource_sel, speed_select, power_down_bit};

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic conclude;
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Inputs always move 1 ns after the edge
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // Hold valid until an edge sees ready, then wait for the load and settling
  task automatic send(input logic [15:0] w);
    word_valid = 1'b1;
    word_data  = w;
    for (n = 0; n < 100 && word_ready !== 1'b1; n++) tick();
    tick();
    word_valid = 1'b0;
    for (n = 0; n < 200 && update_pulse !== 1'b1; n++) tick();
    chk("update_pulse", 40'h1, 40'(update_pulse));
    for (stl = 0; stl < 1000 && settling === 1'b1; stl++) tick();
  endtask

  initial begin
    rst_n      = 1'b0;
    word_valid = 1'b0;
    word_data  = 16'h0000;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    tick();
    chk("reset", 40'h0, seen);
    // Every reference code, with junk in the ignored data bits
    for (int r = 0; r < 4; r++) begin
      send(16'hdffc | 16'(r));
      chk("control", {2'(r), 1'(r == 0 || r == 3), 2'b10},
        {vsource_sel, vsource_external, speed_select, power_down_bit});
    end
    // Each route, mode bit and settle length
    for (int i = 0; i < 6; i++) begin
      send(tbl[i][0]);
      chk("latches", {tbl[i][1][11:0], tbl[i][2][11:0], tbl[i][3][11:0], 2'b11, tbl[i][4][1:0]},
        seen);
      chk("scale", {1'b0, tbl[i][1][11:0], 1'b0, tbl[i][2][11:0]},
        {out_scale_a, out_scale_b});
      if (sexp[i] > 0)
        chk("settle", 40'h1, 40'(stl >= sexp[i] - 3 && stl <= sexp[i] + 3));
    end
    // Fill the buffer back to back until refused, then drain
    word_valid = 1'b1;
    word_data  = 16'h4555;
    for (n = 0; n < 6 && word_ready === 1'b1; n++) tick();
    word_valid = 1'b0;
    chk("fill", 40'h1, 40'(n >= 2 && word_ready === 1'b0));
    for (n = 0; n < 2000 && busy === 1'b1; n++) tick();
    chk("idle", 40'h0, 40'(busy));
    repeat (12) tick();
    chk("drained", 40'h555, 40'(dac_b_code));
    conclude();
  end

  // Whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    conclude();
  end
endmodule // tb_top
